// file: rtl/codec_serial_defs.vh
`ifndef CODEC_SERIAL_DEFS_VH
`define CODEC_SERIAL_DEFS_VH
// ==================================================================
// register map, byte addresses on the axi4-lite port
`define REG_CTRL      5'h00
`define REG_STATUS    5'h04
`define REG_CTRL_WORD 5'h08
`define REG_FRAMES    5'h0C
`define REG_RX_DATA   5'h10
// ==================================================================
// bus response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// ==================================================================
// control register fields and reset value
`define CTRL_EN_BIT   0
`define CTRL_RESET    32'h0000_0000
// ==================================================================
// control word layout, msb-first numbering
`define CW_BITS       32
`define CW_MIN_BITS   6'h1F
`define CW_MAX_BITS   6'h20
`define CW_RESET      32'h0000_0000
`define CW_MASK_IRQ   30
`define CW_LATT_HI    28
`define CW_LATT_LO    24
`define CW_RATT_HI    23
`define CW_RATT_LO    19
`define CW_MUTE       18
`define CW_LSEL       17
`define CW_RSEL       16
`define CW_LGAIN_HI   15
`define CW_LGAIN_LO   12
`define CW_RGAIN_HI   11
`define CW_RGAIN_LO   8
// ==================================================================
// sample port timing: aclk 10 ns, bit clock period in ns
`define CLK_PERIOD_NS 10
`define BCLK_PERIOD_NS 160
`define BCLK_HALF     4'h8 // aclk cycles per half bit clock
`define FRAME_LAST    5'h1F
`define FRAME_START   5'h1E
`define WORD_BITS     16
`define FIFO_DEPTH    8
`define FIFO_AW       3
`endif

// file: rtl/codec_serial_if.v
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "codec_serial_defs.vh"
`default_nettype none
// ==================================================================
// sample fifo: width and depth shape the storage
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             aclk,     // system clock
  input  wire             aresetn,  // sync reset, active low
  input  wire             in_valid, // write request
  output wire             in_ready, // room available
  input  wire [WIDTH-1:0] in_data,  // write data
  output wire             out_valid,// data available
  input  wire             out_ready,// read request
  output wire [WIDTH-1:0] out_data, // head of queue
  output wire [AW:0]      level     // words stored
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_r;
  reg [AW:0]      rd_r;
  wire            push;
  wire            pop;
  // full when pointers differ only in the wrap bit
  assign level     = wr_r - rd_r;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (wr_r != rd_r);
  assign out_data  = mem[rd_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // pointer and storage update
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_r[AW-1:0]] <= in_data;
        wr_r              <= wr_r + 1'b1;
      end
      if (pop)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule

// ==================================================================
// Summary of operation
// - samples use the sample port, configuration the separate control port
// - codec is bit clock master and drives the bit clock out
// - codec drives the frame sync one bit ahead of each frame
// - control bit 30 masks the codec interrupt pin when set
// - bits 28..24 left output attenuation, 1.5 dB steps
// - bits 23..19 right output attenuation, 1.5 dB steps
// - bit 18 mutes the analog output when set
// - bits 17 and 16 pick line input one or two, left and right
// - bits 15..12 left input gain, 1.5 dB steps
// - bits 11..8 right input gain, 1.5 dB steps
// - first control bit shifted is bit 31 of this numbering
// - frame is 16-bit left then 16-bit right, msb first
module codec_serial_if (
  input  wire        aclk,             // system clock, 100 MHz
  input  wire        aresetn,          // sync reset, active low
  input  wire [4:0]  s_axi_awaddr,     // write address
  input  wire        s_axi_awvalid,    // write address valid
  output wire        s_axi_awready,    // write address ready
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire        s_axi_wvalid,     // write data valid
  output wire        s_axi_wready,     // write data ready
  output reg  [1:0]  s_axi_bresp,      // write response
  output reg         s_axi_bvalid,     // write response valid
  input  wire        s_axi_bready,     // write response ready
  input  wire [4:0]  s_axi_araddr,     // read address
  input  wire        s_axi_arvalid,    // read address valid
  output wire        s_axi_arready,    // read address ready
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read response
  output reg         s_axi_rvalid,     // read data valid
  input  wire        s_axi_rready,     // read data ready
  input  wire        codec_reset_n,    // codec reset pin from host
  input  wire        ctrl_select_n,    // control gate pin, active low
  input  wire        ctrl_clock,       // control clock pin from host
  input  wire        ctrl_data_in,     // control data pin
  output reg         sample_bit_clock, // bit clock to host
  output reg         frame_sync_pulse, // frame sync to host
  output reg         codec_sample_out, // serial samples to host
  input  wire        codec_sample_in,  // serial samples from host
  output wire        codec_irq_pin_n,  // interrupt pin, active low
  input  wire [31:0] adc_data,         // left in 31..16, right in 15..0
  input  wire        adc_valid,        // converter word offered
  output wire        adc_ready,        // fifo has room
  output reg  [31:0] dac_data,         // received left and right word
  output reg         dac_valid,        // one-cycle pulse per frame
  output reg         irq_mask,         // interrupt masked
  output reg  [4:0]  left_atten,       // left output attenuation
  output reg  [4:0]  right_atten,      // right output attenuation
  output reg         out_mute,         // analog output muted
  output reg         left_input_two,   // left uses second line input
  output reg         right_input_two,  // right uses second line input
  output reg  [3:0]  left_gain,        // left input gain
  output reg  [3:0]  right_gain        // right input gain
);
  localparam [3:0] HALF = `BCLK_HALF;
  // ================================================================
  // pin synchronisers, two flops each
  reg [1:0] rst_s_r;
  reg [1:0] sel_s_r;
  reg [1:0] clk_s_r;
  reg [1:0] din_s_r;
  reg [1:0] sin_s_r;
  reg       clk_d_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_s_r <= 2'h0;
      sel_s_r <= 2'h3;
      clk_s_r <= 2'h0;
      din_s_r <= 2'h0;
      sin_s_r <= 2'h0;
      clk_d_r <= 1'b0;
    end else begin
      rst_s_r <= {rst_s_r[0], codec_reset_n};
      sel_s_r <= {sel_s_r[0], ctrl_select_n};
      clk_s_r <= {clk_s_r[0], ctrl_clock};
      din_s_r <= {din_s_r[0], ctrl_data_in};
      sin_s_r <= {sin_s_r[0], codec_sample_in};
      clk_d_r <= clk_s_r[1];
    end
  end
  // codec held in reset by either the system or the host line
  wire run = aresetn & rst_s_r[1];
  // ================================================================
  // control port receiver
  reg [31:0] cw_sh_r;
  reg [5:0]  cw_cnt_r;
  reg [31:0] cw_r;
  reg        cw_loaded_r;
  reg        sel_d_r;
  wire       ctrl_clock_rise = clk_s_r[1] & ~clk_d_r;
  always @(posedge aclk) begin
    if (!run) begin
      cw_sh_r     <= `CW_RESET;
      cw_cnt_r    <= 6'h00;
      cw_r        <= `CW_RESET;
      cw_loaded_r <= 1'b0;
      sel_d_r     <= 1'b1;
    end else begin
      sel_d_r <= sel_s_r[1];
      if (sel_s_r[1]) begin
        // end of transfer: accept only a full enough word
        cw_cnt_r <= 6'h00;
        if (!sel_d_r && cw_cnt_r >= `CW_MIN_BITS) begin
          cw_r        <= cw_sh_r;
          cw_loaded_r <= 1'b1;
        end
      end else if (ctrl_clock_rise && cw_cnt_r < `CW_MAX_BITS) begin
        // first bit lands in bit 31, later bits fall below it
        cw_sh_r[5'h1F - cw_cnt_r[4:0]] <= din_s_r[1];
        cw_cnt_r                       <= cw_cnt_r + 1'b1;
      end else if (sel_d_r) begin
        cw_sh_r <= `CW_RESET;
      end
    end
  end
  // control word fields to the analog section
  always @(posedge aclk) begin
    irq_mask        <= cw_r[`CW_MASK_IRQ];
    left_atten      <= cw_r[`CW_LATT_HI:`CW_LATT_LO];
    right_atten     <= cw_r[`CW_RATT_HI:`CW_RATT_LO];
    out_mute        <= cw_r[`CW_MUTE];
    left_input_two  <= cw_r[`CW_LSEL];
    right_input_two <= cw_r[`CW_RSEL];
    left_gain       <= cw_r[`CW_LGAIN_HI:`CW_LGAIN_LO];
    right_gain      <= cw_r[`CW_RGAIN_HI:`CW_RGAIN_LO];
  end
  // ================================================================
  // converter word fifo in the transmit path
  reg         en_r;
  wire        fifo_valid;
  wire [31:0] fifo_data;
  wire [3:0]  fifo_level;
  reg         pop_r;
  sample_fifo #(
    .WIDTH (32),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) tx_fifo (
    .aclk      (aclk),
    .aresetn   (run),
    .in_valid  (adc_valid),
    .in_ready  (adc_ready),
    .in_data   (adc_data),
    .out_valid (fifo_valid),
    .out_ready (pop_r),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );
  // ================================================================
  // sample port master: bit clock, frame sync, data
  reg [3:0]  div_r;
  reg [4:0]  bit_r;
  reg [31:0] tx_sh_r;
  reg [31:0] rx_sh_r;
  reg        underrun_r;
  reg [31:0] frames_r;
  reg        rx_full_r;
  always @(posedge aclk) begin
    if (!run || !en_r) begin
      div_r            <= 4'h0;
      bit_r            <= `FRAME_START;
      tx_sh_r          <= 32'h0000_0000;
      rx_sh_r          <= 32'h0000_0000;
      sample_bit_clock <= 1'b0;
      frame_sync_pulse <= 1'b0;
      codec_sample_out <= 1'b0;
      pop_r            <= 1'b0;
      dac_valid        <= 1'b0;
      rx_full_r        <= 1'b0;
      if (!run) begin
        dac_data   <= 32'h0000_0000;
        underrun_r <= 1'b0;
        frames_r   <= 32'h0000_0000;
      end
    end else begin
      pop_r     <= 1'b0;
      dac_valid <= 1'b0;
      if (div_r == HALF - 4'h1) begin
        div_r            <= 4'h0;
        sample_bit_clock <= ~sample_bit_clock;
        if (!sample_bit_clock) begin
          // rising edge: launch next bit
          if (bit_r == `FRAME_LAST) begin
            bit_r            <= 5'h00;
            tx_sh_r          <= fifo_valid ? fifo_data : 32'h0000_0000;
            codec_sample_out <= fifo_valid & fifo_data[31];
            pop_r            <= fifo_valid;
            rx_full_r        <= 1'b1;
            underrun_r       <= ~fifo_valid;
            frame_sync_pulse <= 1'b0;
          end else begin
            bit_r            <= bit_r + 5'h01;
            tx_sh_r          <= {tx_sh_r[30:0], 1'b0};
            codec_sample_out <= tx_sh_r[30];
            frame_sync_pulse <= (bit_r == `FRAME_LAST - 5'h01);
          end
        end else begin
          // falling edge: capture host data
          rx_sh_r <= {rx_sh_r[30:0], sin_s_r[1]};
          // no strobe for the sync slot that precedes the first full frame
          if (bit_r == `FRAME_LAST && rx_full_r) begin
            dac_data  <= {rx_sh_r[30:0], sin_s_r[1]};
            dac_valid <= 1'b1;
            frames_r  <= frames_r + 32'h0000_0001;
          end
        end
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end
  // interrupt pin: underrun of the last frame, unless masked
  assign codec_irq_pin_n = ~(underrun_r & ~cw_r[`CW_MASK_IRQ]);
  // ================================================================
  // axi4-lite slave
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [4:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  wire       aw_ok = aw_hold_r | s_axi_awvalid;
  wire       w_ok  = w_hold_r | s_axi_wvalid;
  wire [4:0] wa    = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd   = w_hold_r ? w_data_r : s_axi_wdata;
  wire [3:0] ws    = w_hold_r ? w_strb_r : s_axi_wstrb;
  wire       do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // write side: either channel may arrive first
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 5'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      en_r         <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (wa)
          `REG_CTRL: begin
            if (ws[0])
              en_r <= wd[`CTRL_EN_BIT];
          end
          `REG_STATUS, `REG_CTRL_WORD, `REG_FRAMES, `REG_RX_DATA: en_r <= en_r;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
      end
    end
  end
  // read side: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL:      s_axi_rdata <= {31'h0000_0000, en_r};
        `REG_STATUS:    s_axi_rdata <= {24'h00_0000, fifo_level, ~codec_irq_pin_n,
                                        underrun_r, cw_loaded_r, run};
        `REG_CTRL_WORD: s_axi_rdata <= cw_r;
        `REG_FRAMES:    s_axi_rdata <= frames_r;
        `REG_RX_DATA:   s_axi_rdata <= dac_data;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verif/codec_serial_asserts.sv
`default_nettype none
// ==========
// port checker for the codec serial interface
module codec_serial_asserts (
  input wire logic        aclk,             // system clock
  input wire logic        aresetn,          // sync reset
  input wire logic        s_axi_bvalid,     // write response valid
  input wire logic        s_axi_bready,     // write response ready
  input wire logic [1:0]  s_axi_bresp,      // write response
  input wire logic        s_axi_rvalid,     // read valid
  input wire logic        s_axi_rready,     // read ready
  input wire logic        s_axi_arready,    // read address ready
  input wire logic [31:0] s_axi_rdata,      // read data
  input wire logic        codec_reset_n,    // codec reset pin
  input wire logic        ctrl_select_n,    // control gate pin
  input wire logic        sample_bit_clock, // bit clock out
  input wire logic        frame_sync_pulse, // frame sync out
  input wire logic        codec_sample_out, // samples out
  input wire logic        codec_irq_pin_n,  // interrupt pin
  input wire logic        dac_valid,        // frame received
  input wire logic        irq_mask,         // interrupt masked
  input wire logic [4:0]  left_atten,       // left attenuation
  input wire logic [4:0]  right_atten,      // right attenuation
  input wire logic        out_mute,         // output muted
  input wire logic        left_input_two,   // left source
  input wire logic        right_input_two,  // right source
  input wire logic [3:0]  left_gain,        // left gain
  input wire logic [3:0]  right_gain        // right gain
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sel_d;
  logic [3:0] sel_age;
  // cycles since the control gate closed, saturating
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_d   <= 1'b1;
      sel_age <= 4'hF;
    end else begin
      sel_d <= ctrl_select_n;
      if (ctrl_select_n && !sel_d) sel_age <= 4'h0;
      else if (sel_age != 4'hF) sel_age <= sel_age + 4'h1;
    end
  end
  // codec reset also stops the sample port, so it silences the checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !codec_reset_n);
  chk_sync_len: assert property ($rose(frame_sync_pulse) |->
    frame_sync_pulse[*8] ##1 frame_sync_pulse[*8] ##1 !frame_sync_pulse)
    else $error("frame sync not one bit long");
  chk_sync_edge: assert property ($rose(frame_sync_pulse) |-> $rose(sample_bit_clock))
    else $error("frame sync off the bit clock edge");
  chk_bclk_period: assert property ($rose(sample_bit_clock) |->
    sample_bit_clock[*8] ##1 !sample_bit_clock[*8] ##1 sample_bit_clock)
    else $error("bit clock period wrong");
  chk_frame_gap: assert property ($rose(frame_sync_pulse) |->
    ##[512:512] $rose(frame_sync_pulse))
    else $error("frame not 32 bits long");
  chk_out_timing: assert property ($changed(codec_sample_out) |->
    $rose(sample_bit_clock))
    else $error("sample out moved off its slot");
  chk_irq_mask: assert property (!codec_irq_pin_n |=> !irq_mask)
    else $error("interrupt pin active while masked");
  chk_field_time: assert property ($changed({irq_mask, left_atten, right_atten,
    out_mute, left_input_two, right_input_two, left_gain, right_gain}) |-> sel_age < 4'h9)
    else $error("settings moved without a control transfer");
  chk_dac_pulse: assert property (dac_valid |=> !dac_valid[*8])
    else $error("receive strobe too long");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && !s_axi_arready && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule
bind codec_serial_if codec_serial_asserts i_chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_arready, .s_axi_rdata, .codec_reset_n, .ctrl_select_n,
  .sample_bit_clock, .frame_sync_pulse, .codec_sample_out, .codec_irq_pin_n, .dac_valid,
  .irq_mask, .left_atten, .right_atten, .out_mute, .left_input_two, .right_input_two,
  .left_gain, .right_gain
);
`default_nettype wire

// file: verif/codec_host_model.sv
`default_nettype none
// ==========
// host side: reset line, control port and sample port
module codec_host_model (
  input  wire logic        aclk,             // system clock
  input  wire logic        sample_bit_clock, // bit clock from codec
  input  wire logic        frame_sync_pulse, // frame sync from codec
  input  wire logic        codec_sample_out, // samples from codec
  input  wire logic [31:0] tx_word,          // next frame to send
  output var  logic        codec_reset_n,    // codec reset, active low
  output var  logic        ctrl_select_n,    // control gate, active low
  output var  logic        ctrl_clock,       // control clock
  output var  logic        ctrl_data_in,     // control data
  output var  logic        codec_sample_in   // samples to codec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        armed;
  logic [31:0] tx_sh, rx_sh, rx_word;
  int          tk, rk, rx_n, tx_n;
  // codec held in reset until the host lets it go
  initial begin
    {ctrl_select_n, codec_reset_n, ctrl_clock, ctrl_data_in, codec_sample_in} = 5'b10000;
    {rx_n, tx_n, tk, rk, armed} = {32'd0, 32'd0, 32'd32, 32'd32, 1'b0};
    repeat (16) @(posedge aclk);
    codec_reset_n <= 1'b1;
  end
  // reset pulse on request
  task hold_reset;
    @(posedge aclk) codec_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    codec_reset_n <= 1'b1;
  endtask
  // one gated control transfer, highest bit first, only when asked for
  task send_ctrl(input logic [31:0] cw, input int nb);
    ctrl_select_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      ctrl_data_in <= cw[31 - i];
      #80 ctrl_clock <= 1'b1;
      #80 ctrl_clock <= 1'b0;
    end
    #80 ctrl_select_n <= 1'b1;
    ctrl_data_in <= ~ctrl_data_in; // released line keeps no stale bit
    #80;
  endtask
  // send a frame starting at the rise after the sync slot
  always @(posedge sample_bit_clock) begin
    #1;
    if (armed) begin
      tx_sh = tx_word;
      tk = 0;
      tx_n++;
    end
    armed = frame_sync_pulse;
    if (tk < 32) begin
      codec_sample_in = tx_sh[31 - tk];
      tk++;
    end else codec_sample_in = ~codec_sample_in;
  end
  // capture on falling edges, last bit shares the next sync slot
  always @(negedge sample_bit_clock) begin
    if (rk < 32) begin
      rx_sh = {rx_sh[30:0], codec_sample_out};
      rk++;
      if (rk == 32) begin
        rx_word = rx_sh;
        rx_n++;
      end
    end
    if (frame_sync_pulse) rk = 0;
  end
endmodule
`default_nettype wire

// file: verif/stereo_codec_serial_interface_tb_top.sv
`include "codec_serial_defs.vh"
`default_nettype none
module stereo_codec_serial_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, adc_valid;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, adc_data, tx_word, w;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [31:0] aq[$], dq[$];
  int          err_total, n_tests, seed, k;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   codec_reset_n, ctrl_select_n, ctrl_clock, ctrl_data_in, sample_bit_clock;
  wire logic   frame_sync_pulse, codec_sample_out, codec_sample_in, codec_irq_pin_n;
  wire logic   adc_ready, dac_valid, irq_mask, out_mute, left_input_two, right_input_two;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, dac_data;
  wire logic [4:0]  left_atten, right_atten;
  wire logic [3:0]  left_gain, right_gain;
  codec_serial_if i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .codec_reset_n, .ctrl_select_n, .ctrl_clock, .ctrl_data_in,
    .sample_bit_clock, .frame_sync_pulse, .codec_sample_out, .codec_sample_in,
    .codec_irq_pin_n, .adc_data, .adc_valid, .adc_ready, .dac_data, .dac_valid, .irq_mask,
    .left_atten, .right_atten, .out_mute, .left_input_two, .right_input_two, .left_gain,
    .right_gain);
  codec_host_model i_host (.aclk, .sample_bit_clock, .frame_sync_pulse, .codec_sample_out,
    .tx_word, .codec_reset_n, .ctrl_select_n, .ctrl_clock, .ctrl_data_in, .codec_sample_in);
  // ==========
  // clock, watchdog, shared checks
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #400us;
    err_total++;
    summarize();
  end
  task automatic cmp(input logic bad, input string m);
    n_tests++;
    if (bad !== 1'b0) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task summarize;
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk_fields(input logic [31:0] v);
    cmp({irq_mask, left_atten, right_atten, out_mute, left_input_two, right_input_two,
      left_gain, right_gain} !== {v[`CW_MASK_IRQ], v[`CW_LATT_HI:`CW_RGAIN_LO]}, "settings");
  endtask
  // ==========
  // bus master
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    k = 0;
    while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && k < 99) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp(k >= 99, "write timeout");
  endtask
  // read answer is made to wait one cycle before rready rises
  task rd(input logic [4:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      else if (!s_axi_arvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && k < 99);
    s_axi_rready <= 1'b0;
    cmp(k >= 99, "read timeout");
  endtask
  // ==========
  // result watchers take the oldest note per result
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp(bq.size() == 0 || s_axi_bresp !== bq.pop_front(),
      "write response");
    if (s_axi_rvalid && s_axi_rready) cmp(rq.size() == 0 ||
      {s_axi_rresp, s_axi_rdata} !== rq.pop_front(), "read data");
    if (dac_valid) cmp(dq.size() == 0 || dac_data !== dq.pop_front(), "host frame");
  end
  always @(i_host.rx_n) cmp(i_host.rx_word !== (aq.size() ? aq.pop_front() : 32'h0),
    "codec frame");
  // note each frame the host sends, then offer a new one
  always @(i_host.tx_n) begin
    dq.push_back(tx_word);
    @(posedge aclk) tx_word <= $random(seed);
  end
  // ==========
  // main sequence
  initial begin
    {err_total, n_tests, seed, aresetn, adc_valid, adc_data} = {32'd0, 32'd0, 32'd66, 34'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {42'h0, 4'hF};
    tx_word = $random(seed);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(`REG_CTRL, {`RESP_OKAY, `CTRL_RESET});
    rd(`REG_CTRL_WORD, {`RESP_OKAY, `CW_RESET});
    rd(5'h14, {`RESP_SLVERR, 32'h0});
    wr(5'h14, 32'h1, `RESP_SLVERR);
    wr(`REG_STATUS, 32'hF, `RESP_OKAY);
    // full, 31-bit, full, full, then a short refused transfer
    for (int i = 0; i < 5; i++) begin
      if (i < 4) w = ($random(seed) & 32'h3FFF_FF00) | ((i == 0) << `CW_MASK_IRQ);
      i_host.send_ctrl(i == 4 ? ~w : (i == 1 ? w | 32'h1 : w),
        i == 1 ? 31 : (i == 4 ? 20 : 32));
      repeat (10) @(posedge aclk);
      chk_fields(w);
      rd(`REG_CTRL_WORD, {`RESP_OKAY, w});
    end
    // fill the fifo until it refuses
    k = 0;
    adc_valid <= 1'b1;
    adc_data <= $random(seed);
    repeat (12) begin
      @(posedge aclk);
      if (adc_ready) begin
        aq.push_back(adc_data);
        k++;
        adc_data <= $random(seed);
      end
    end
    adc_valid <= 1'b0;
    cmp(k !== `FIFO_DEPTH, "fifo depth");
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    k = 0;
    while (i_host.rx_n < 10 && k < 9000) begin
      @(posedge aclk);
      k++;
    end
    cmp(k >= 9000, "frame timeout");
    cmp(codec_irq_pin_n !== 1'b0, "underrun interrupt");
    i_host.send_ctrl(w | 32'h4000_0000, 32);
    repeat (10) @(posedge aclk);
    cmp(codec_irq_pin_n !== 1'b1, "masked interrupt");
    i_host.hold_reset();
    repeat (8) @(posedge aclk);
    chk_fields(32'h0);
    rd(`REG_CTRL_WORD, {`RESP_OKAY, 32'h0});
    summarize();
  end
endmodule
`default_nettype wire
